// *** inc/apcq_pkg.sv ***
// Purpose: Shared constants and types of the axis position counter block
// Assumes: 10 MHz mclk
// Notes: Byte offsets on the Avalon-MM slave, one word each
package apcq_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int FILT_FAST_NS = 50;
    localparam int FILT_SLOW_NS = 150;
    // Shortest guaranteed pulse, so rounded down, never below one cycle
    localparam int FILT_FAST_CYC =
        (FILT_FAST_NS / CLK_PERIOD_NS < 1) ? 1 : FILT_FAST_NS / CLK_PERIOD_NS;
    localparam int FILT_SLOW_CYC =
        (FILT_SLOW_NS / CLK_PERIOD_NS < 1) ? 1 : FILT_SLOW_NS / CLK_PERIOD_NS;
    localparam int AW = 5;
    localparam logic [4:0] OFS_CONFIG = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_CTR1 = 5'h0C;
    localparam logic [4:0] OFS_CTR2 = 5'h10;
    localparam logic [4:0] OFS_CTR3 = 5'h14;
    localparam logic [4:0] OFS_CTR4 = 5'h18;
    localparam int CFG_W = 16;
    localparam int CFG_C2_LSB = 0;
    localparam int CFG_DEV_LSB = 2;
    localparam int CFG_C4_LSB = 4;
    localparam int CFG_EFMT_LSB = 6;
    localparam int CFG_EREV_BIT = 8;
    localparam int CFG_EOFF_BIT = 9;
    localparam int CFG_EFLT_BIT = 10;
    localparam int CFG_HFMT_LSB = 11;
    localparam int CFG_HREV_BIT = 13;
    localparam int CFG_HOFF_BIT = 14;
    localparam int CFG_HFLT_BIT = 15;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam int EVT_W = 2;
    localparam int EVT_ENC_BIT = 0;
    localparam int EVT_HW_BIT = 1;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam int POS_W = 32;
    localparam int DEV_W = 16;
    typedef enum logic [1:0] {
        FMT_X1 = 2'b00,
        FMT_X2 = 2'b01,
        FMT_X4 = 2'b10,
        FMT_TWO_PULSE = 2'b11
    } apcq_fmt_type;
    typedef enum logic [1:0] {
        C2_ENC = 2'b00,
        C2_CMD = 2'b01,
        C2_HW = 2'b10
    } apcq_c2_type;
    typedef enum logic [1:0] {
        DEV_CMD_ENC = 2'b00,
        DEV_CMD_HW = 2'b01,
        DEV_ENC_HW = 2'b10
    } apcq_dev_type;
    typedef enum logic [1:0] {
        C4_CMD = 2'b00,
        C4_ENC = 2'b01,
        C4_HW = 2'b10,
        C4_HALF = 2'b11
    } apcq_c4_type;
endpackage

// *** inc/apcq_step_if.sv ***
// Purpose: Count steps from a phase decoder to the counters
// Assumes: One-cycle pulses on mclk
// Notes: up and dn never high together
`timescale 1ns/1ps
interface apcq_step_if;
    logic up;
    logic dn;
    logic err;
    modport src (output up, output dn, output err);
    modport snk (input up, input dn, input err);
endinterface

// *** core/apcq_counter.sv ***
// Purpose: Up/down counter with software load
// Assumes: inc and dec are one-cycle pulses
// Notes: Load wins over counting in the same cycle
`timescale 1ns/1ps
module apcq_counter #(
    parameter int W = 32
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic inc,
    input wire logic dec,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic [W-1:0] value
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } apcq_ctr_state_type;
    apcq_ctr_state_type q_r;
    apcq_ctr_state_type q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (load) begin
            q_nxt.cnt = load_val;
        end else if (inc && !dec) begin
            q_nxt.cnt = q_r.cnt + W'(1);
        end else if (dec && !inc) begin
            q_nxt.cnt = q_r.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign value = q_r.cnt;
endmodule

// *** core/apcq_decoder.sv ***
// Purpose: Two-phase input decoder, x1/x2/x4 quadrature and two-pulse
// Assumes: Phase inputs asynchronous to mclk
// Notes: Three cycles from pin to step pulse with the shortest filter
`timescale 1ns/1ps
module apcq_decoder (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic phase_a,
    input wire logic phase_b,
    input apcq_pkg::apcq_fmt_type fmt,
    input wire logic reverse,
    input wire logic inputs_off,
    input wire logic filter_sel,
    apcq_step_if.src step
);
    typedef struct packed {
        logic a_s1;
        logic a_s2;
        logic b_s1;
        logic b_s2;
        logic [1:0] a_cnt;
        logic [1:0] b_cnt;
        logic fa;
        logic fb;
        logic up;
        logic dn;
        logic err;
    } apcq_dec_state_type;
    apcq_dec_state_type q_r;
    apcq_dec_state_type q_nxt;
    logic na, nb, ca, cb, ar, af, br, bf, sim, raw_up, raw_dn;
    logic [1:0] lim;

    // Level is accepted once it has differed for lim samples
    function automatic logic [2:0] filt_step(input logic s, input logic f,
                                             input logic [1:0] cnt, input logic [1:0] lim);
        logic [1:0] c1;
        c1 = cnt + 2'h1;
        if (s == f) begin
            filt_step = {f, 2'h0};
        end else if (c1 >= lim) begin
            filt_step = {s, 2'h0};
        end else begin
            filt_step = {f, c1};
        end
    endfunction

    always_comb begin
        q_nxt = q_r;
        q_nxt.a_s1 = phase_a;
        q_nxt.a_s2 = q_r.a_s1;
        q_nxt.b_s1 = phase_b;
        q_nxt.b_s2 = q_r.b_s1;
        lim = filter_sel ? 2'(apcq_pkg::FILT_SLOW_CYC) : 2'(apcq_pkg::FILT_FAST_CYC);
        {na, q_nxt.a_cnt} = filt_step(q_r.a_s2, q_r.fa, q_r.a_cnt, lim);
        {nb, q_nxt.b_cnt} = filt_step(q_r.b_s2, q_r.fb, q_r.b_cnt, lim);
        q_nxt.fa = na;
        q_nxt.fb = nb;
        ca = na ^ q_r.fa;
        cb = nb ^ q_r.fb;
        ar = ca & na;
        af = ca & ~na;
        br = cb & nb;
        bf = cb & ~nb;
        raw_up = 1'b0;
        raw_dn = 1'b0;
        unique case (fmt)
            apcq_pkg::FMT_X1: begin
                raw_up = ar & ~q_r.fb;
                raw_dn = af & ~q_r.fb;
            end
            apcq_pkg::FMT_X2: begin
                raw_up = (ar & ~q_r.fb) | (af & q_r.fb);
                raw_dn = (ar & q_r.fb) | (af & ~q_r.fb);
            end
            apcq_pkg::FMT_X4: begin
                raw_up = (ar & ~q_r.fb) | (af & q_r.fb) | (br & q_r.fa) | (bf & ~q_r.fa);
                raw_dn = (ar & q_r.fb) | (af & ~q_r.fb) | (br & ~q_r.fa) | (bf & q_r.fa);
            end
            apcq_pkg::FMT_TWO_PULSE: begin
                raw_up = ar;
                raw_dn = br;
            end
        endcase
        // A simultaneous change is ambiguous, so it counts nothing
        sim = (fmt == apcq_pkg::FMT_TWO_PULSE) ? (ar & br) : (ca & cb);
        q_nxt.up = ~inputs_off & ~sim & (reverse ? raw_dn : raw_up);
        q_nxt.dn = ~inputs_off & ~sim & (reverse ? raw_up : raw_dn);
        q_nxt.err = ~inputs_off & sim;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign step.up = q_r.up;
    assign step.dn = q_r.dn;
    assign step.err = q_r.err;

    default clocking cb_dec @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_x1_up;
        fmt == apcq_pkg::FMT_X1 && !inputs_off && !reverse && ar && !cb && !q_r.fb |=> step.up;
    endproperty
    a_x1_up: assert property (p_x1_up) else $error("x1 A rise B low no up");
    property p_x2_up;
        fmt == apcq_pkg::FMT_X2 && !inputs_off && !reverse && af && !cb && q_r.fb |=> step.up;
    endproperty
    a_x2_up: assert property (p_x2_up) else $error("x2 A fall B high no up");
    property p_x4_bdn;
        fmt == apcq_pkg::FMT_X4 && !inputs_off && !reverse && br && !ca && !q_r.fa |=> step.dn;
    endproperty
    a_x4_bdn: assert property (p_x4_bdn) else $error("x4 B rise A low no down");
    property p_two_dn;
        fmt == apcq_pkg::FMT_TWO_PULSE && !inputs_off && !reverse && br && !ar |=> step.dn;
    endproperty
    a_two_dn: assert property (p_two_dn) else $error("two-pulse B rise no down");
    property p_rev;
        fmt == apcq_pkg::FMT_X4 && !inputs_off && reverse && ar && !cb && !q_r.fb |=> step.dn;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse did not swap");
    property p_off;
        inputs_off |=> !step.up && !step.dn && !step.err;
    endproperty
    a_off: assert property (p_off) else $error("disabled input produced output");
    property p_sim;
        fmt != apcq_pkg::FMT_TWO_PULSE && !inputs_off && ca && cb |=> step.err && !step.up;
    endproperty
    a_sim: assert property (p_sim) else $error("simultaneous change not flagged");
    property p_one;
        !(step.up && step.dn);
    endproperty
    a_one: assert property (p_one) else $error("up and down together");
endmodule

// *** core/apcq_top.sv ***
// Purpose: Four position counters, two to four with selectable sources, and decoders
// Assumes: cmd_pulse and cmd_dir synchronous to mclk, one pulse per step
// Notes: Avalon-MM slave, one wait state per access
// Function
// - Counter one counts only the command pulse output.
// - Counters one, two and four are 32 bits wide, counter three is 16 bits.
// - After reset counter two counts encoder, three the command-encoder deviation, four commands.
// - Counter two source is encoder at 00b, command at 01b, handwheel at 10b, 11b forbidden.
// - Deviation source is command-encoder 00b, command-handwheel 01b, encoder-handwheel 10b.
// - Counter four source is command 00b, encoder 01b, handwheel 10b, half mclk at 11b.
// - x1 mode counts up on A rise with B low and down on A fall with B low.
// - x2 mode adds counts on both A edges with B high: up on A fall, down on A rise.
// - x4 mode counts on every edge of both phases by the level of the other phase.
// - Two-pulse mode counts up on A rises and down on B rises.
// - The reverse bit swaps up and down in every encoder mode.
// - The disable bit makes the encoder produce neither counts nor errors.
// - A simultaneous change or arrival of both phases sets the encoder error flag.
// - The filter bit guarantees pulses of 0.05 us at 0 and 0.15 us at 1 are seen; both settings accept a level after one 0.1 us mclk sample.
// - With reverse clear the count rises when A leads, with it set when B leads.
// - An encoder error only raises its flag and stops nothing.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module apcq_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic encoder_phase_a,
    input wire logic encoder_phase_b,
    input wire logic handwheel_phase_a,
    input wire logic handwheel_phase_b,
    input wire logic cmd_pulse,
    input wire logic cmd_dir,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0] status;
        logic [1:0] mask;
        logic [1:0] rd_snap;
        logic wreq;
        logic [31:0] rdata;
        logic half;
        logic irq;
    } apcq_top_state_type;
    apcq_top_state_type q_r;
    apcq_top_state_type q_nxt;

    apcq_step_if e_step ();
    apcq_step_if h_step ();

    logic cmd_up;
    logic cmd_dn;
    logic take;
    logic [3:0] ld;
    logic [1:0] evt;
    logic [1:0] inc;
    logic [1:0] dec;
    logic i3;
    logic d3;
    logic [31:0] ctr1_val;
    logic [31:0] ctr2_val;
    logic [15:0] ctr3_val;
    logic [31:0] ctr4_val;
    apcq_pkg::apcq_c2_type src2;
    apcq_pkg::apcq_dev_type src3;
    apcq_pkg::apcq_c4_type src4;

    // Net of a minus b, clipped to one step so a counter never jumps by two
    function automatic logic [1:0] net_step(input logic a_up, input logic a_dn,
                                            input logic b_up, input logic b_dn);
        net_step = {(a_up | b_dn) & ~(a_dn | b_up), (a_dn | b_up) & ~(a_up | b_dn)};
    endfunction

    apcq_decoder u_enc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .phase_a(encoder_phase_a),
        .phase_b(encoder_phase_b),
        .fmt(apcq_pkg::apcq_fmt_type'(q_r.cfg[apcq_pkg::CFG_EFMT_LSB +: 2])),
        .reverse(q_r.cfg[apcq_pkg::CFG_EREV_BIT]),
        .inputs_off(q_r.cfg[apcq_pkg::CFG_EOFF_BIT]),
        .filter_sel(q_r.cfg[apcq_pkg::CFG_EFLT_BIT]),
        .step(e_step.src)
    );

    apcq_decoder u_hw (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .phase_a(handwheel_phase_a),
        .phase_b(handwheel_phase_b),
        .fmt(apcq_pkg::apcq_fmt_type'(q_r.cfg[apcq_pkg::CFG_HFMT_LSB +: 2])),
        .reverse(q_r.cfg[apcq_pkg::CFG_HREV_BIT]),
        .inputs_off(q_r.cfg[apcq_pkg::CFG_HOFF_BIT]),
        .filter_sel(q_r.cfg[apcq_pkg::CFG_HFLT_BIT]),
        .step(h_step.src)
    );

    apcq_counter #(.W(apcq_pkg::POS_W)) u_ctr1 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inc(cmd_up),
        .dec(cmd_dn),
        .load(ld[0]),
        .load_val(avs_writedata),
        .value(ctr1_val)
    );

    apcq_counter #(.W(apcq_pkg::POS_W)) u_ctr2 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inc(inc[0]),
        .dec(dec[0]),
        .load(ld[1]),
        .load_val(avs_writedata),
        .value(ctr2_val)
    );

    apcq_counter #(.W(apcq_pkg::DEV_W)) u_ctr3 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inc(i3),
        .dec(d3),
        .load(ld[2]),
        .load_val(avs_writedata[15:0]),
        .value(ctr3_val)
    );

    apcq_counter #(.W(apcq_pkg::POS_W)) u_ctr4 (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inc(inc[1]),
        .dec(dec[1]),
        .load(ld[3]),
        .load_val(avs_writedata),
        .value(ctr4_val)
    );

    always_comb begin
        cmd_up = cmd_pulse & ~cmd_dir;
        cmd_dn = cmd_pulse & cmd_dir;
        src2 = apcq_pkg::apcq_c2_type'(q_r.cfg[apcq_pkg::CFG_C2_LSB +: 2]);
        src3 = apcq_pkg::apcq_dev_type'(q_r.cfg[apcq_pkg::CFG_DEV_LSB +: 2]);
        src4 = apcq_pkg::apcq_c4_type'(q_r.cfg[apcq_pkg::CFG_C4_LSB +: 2]);

        unique case (src2)
            apcq_pkg::C2_ENC: begin
                inc[0] = e_step.up;
                dec[0] = e_step.dn;
            end
            apcq_pkg::C2_CMD: begin
                inc[0] = cmd_up;
                dec[0] = cmd_dn;
            end
            apcq_pkg::C2_HW: begin
                inc[0] = h_step.up;
                dec[0] = h_step.dn;
            end
            default: {inc[0], dec[0]} = 2'h0;
        endcase

        unique case (src3)
            apcq_pkg::DEV_CMD_ENC: {i3, d3} = net_step(cmd_up, cmd_dn, e_step.up, e_step.dn);
            apcq_pkg::DEV_CMD_HW: {i3, d3} = net_step(cmd_up, cmd_dn, h_step.up, h_step.dn);
            apcq_pkg::DEV_ENC_HW: {i3, d3} = net_step(e_step.up, e_step.dn, h_step.up, h_step.dn);
            default: {i3, d3} = 2'h0;
        endcase

        unique case (src4)
            apcq_pkg::C4_CMD: begin
                inc[1] = cmd_up;
                dec[1] = cmd_dn;
            end
            apcq_pkg::C4_ENC: begin
                inc[1] = e_step.up;
                dec[1] = e_step.dn;
            end
            apcq_pkg::C4_HW: begin
                inc[1] = h_step.up;
                dec[1] = h_step.dn;
            end
            apcq_pkg::C4_HALF: begin
                inc[1] = q_r.half;
                dec[1] = 1'b0;
            end
        endcase
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.half = ~q_r.half;
        take = (avs_read | avs_write) & ~q_r.wreq;
        ld = 4'h0;
        q_nxt.wreq = 1'b1;

        if ((avs_read || avs_write) && q_r.wreq) begin
            q_nxt.wreq = 1'b0;
            q_nxt.rd_snap = 2'h0;
            q_nxt.rdata = 32'h0000_0000;
            if (avs_read) begin
                unique case (avs_address)
                    apcq_pkg::OFS_CONFIG: q_nxt.rdata = 32'(q_r.cfg);
                    apcq_pkg::OFS_STATUS: begin
                        q_nxt.rdata = 32'(q_r.status);
                        q_nxt.rd_snap = q_r.status;
                    end
                    apcq_pkg::OFS_MASK: q_nxt.rdata = 32'(q_r.mask);
                    apcq_pkg::OFS_CTR1: q_nxt.rdata = ctr1_val;
                    apcq_pkg::OFS_CTR2: q_nxt.rdata = ctr2_val;
                    apcq_pkg::OFS_CTR3: q_nxt.rdata = 32'(ctr3_val);
                    apcq_pkg::OFS_CTR4: q_nxt.rdata = ctr4_val;
                    default: q_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        if (take && avs_write) begin
            unique case (avs_address)
                apcq_pkg::OFS_CONFIG: q_nxt.cfg = avs_writedata[apcq_pkg::CFG_W-1:0];
                apcq_pkg::OFS_MASK: q_nxt.mask = avs_writedata[apcq_pkg::EVT_W-1:0];
                apcq_pkg::OFS_CTR1: ld[0] = 1'b1;
                apcq_pkg::OFS_CTR2: ld[1] = 1'b1;
                apcq_pkg::OFS_CTR3: ld[2] = 1'b1;
                apcq_pkg::OFS_CTR4: ld[3] = 1'b1;
                default: ld = 4'h0;
            endcase
        end

        // Clear only what the read returned, so a later event survives
        if (take && avs_read && avs_address == apcq_pkg::OFS_STATUS) begin
            q_nxt.status = q_r.status & ~q_r.rd_snap;
        end

        evt = 2'h0;
        evt[apcq_pkg::EVT_ENC_BIT] = e_step.err;
        evt[apcq_pkg::EVT_HW_BIT] = h_step.err;
        // The error only flags; counting and motion carry on
        q_nxt.status = q_nxt.status | evt;
        q_nxt.irq = |(q_nxt.status & q_nxt.mask);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q_r <= '0;
            q_r.cfg <= apcq_pkg::CFG_RST;
            q_r.status <= apcq_pkg::STATUS_RST;
            q_r.mask <= apcq_pkg::MASK_RST;
            q_r.wreq <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign avs_readdata = q_r.rdata;
    assign avs_waitrequest = q_r.wreq;
    assign irq = q_r.irq;

    default clocking cb_top @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_ctr1_cmd;
        $changed(ctr1_val) |-> $past(cmd_pulse) || $past(ld[0]);
    endproperty
    a_ctr1_cmd: assert property (p_ctr1_cmd) else $error("ctr1 moved without command");

    property p_dev_wrap;
        ctr3_val == 16'hFFFF && i3 && !ld[2] |=> ctr3_val == 16'h0000;
    endproperty
    a_dev_wrap: assert property (p_dev_wrap) else $error("deviation not 16 bits");

    property p_dflt_enc;
        q_r.cfg == 16'h0000 && e_step.up && !ld[1] |=> ctr2_val == $past(ctr2_val) + 32'h1;
    endproperty
    a_dflt_enc: assert property (p_dflt_enc) else $error("ctr2 default not encoder");

    property p_c2_cmd;
        src2 == apcq_pkg::C2_CMD && cmd_up && !ld[1] |=> ctr2_val == $past(ctr2_val) + 32'h1;
    endproperty
    a_c2_cmd: assert property (p_c2_cmd) else $error("ctr2 command source");

    property p_dev_hw;
        src3 == apcq_pkg::DEV_CMD_HW && cmd_dn && !h_step.up && !h_step.dn && !ld[2]
            |=> ctr3_val == $past(ctr3_val) - 16'h1;
    endproperty
    a_dev_hw: assert property (p_dev_hw) else $error("deviation command source");

    property p_half;
        (src4 == apcq_pkg::C4_HALF && !ld[3]) [*2] |=> ctr4_val == $past(ctr4_val, 2) + 32'h1;
    endproperty
    a_half: assert property (p_half) else $error("ctr4 not at half clock");

    property p_err_flag;
        e_step.err |=> q_r.status[apcq_pkg::EVT_ENC_BIT];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("encoder error lost");

    property p_err_runs;
        e_step.err && cmd_up && !ld[0] |=> ctr1_val == $past(ctr1_val) + 32'h1;
    endproperty
    a_err_runs: assert property (p_err_runs) else $error("error stopped counting");

    property p_hw_err;
        h_step.err |=> q_r.status[apcq_pkg::EVT_HW_BIT];
    endproperty
    a_hw_err: assert property (p_hw_err) else $error("hw error lost");

    property p_irq;
        irq == |(q_r.status & q_r.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");

    property p_c4_enc;
        src4 == apcq_pkg::C4_ENC && e_step.dn && !ld[3] |=> ctr4_val == $past(ctr4_val) - 32'h1;
    endproperty
    a_c4_enc: assert property (p_c4_enc) else $error("ctr4 encoder source");

    property p_c2_hw;
        src2 == apcq_pkg::C2_HW && h_step.up && !ld[1] |=> ctr2_val == $past(ctr2_val) + 32'h1;
    endproperty
    a_c2_hw: assert property (p_c2_hw) else $error("ctr2 handwheel source");

    property p_c3_ld;
        ld[2] |=> ctr3_val == $past(avs_writedata[15:0]);
    endproperty
    a_c3_ld: assert property (p_c3_ld) else $error("ctr3 load");

    property p_dev_eh;
        src3 == apcq_pkg::DEV_ENC_HW && e_step.up && !h_step.up && !h_step.dn && !ld[2]
            |=> ctr3_val == $past(ctr3_val) + 16'h1;
    endproperty
    a_dev_eh: assert property (p_dev_eh) else $error("deviation encoder source");

    // Main scenarios the bench should reach
    c_enc_err: cover property (e_step.err ##1 irq);
    c_half: cover property (src4 == apcq_pkg::C4_HALF ##4 ctr4_val == 32'h2);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_c2_hw: cover property (src2 == apcq_pkg::C2_HW && h_step.up);
    c_dev_eh: cover property (src3 == apcq_pkg::DEV_ENC_HW && e_step.dn);
endmodule

// *** verif/apcq_phase_model.sv ***
// Purpose: Encoder or handwheel phase source
// Assumes: A step request lasts one mclk cycle
// Notes: dual flips both phases at once to provoke an input error
`timescale 1ns/1ps
module apcq_phase_model (
    input wire logic mclk,
    input wire logic step,
    input wire logic dir,
    input wire logic dual,
    input wire logic two_pulse,
    output logic pa,
    output logic pb
);
    logic a_r = 1'h0;
    logic b_r = 1'h0;
    assign pa = a_r;
    assign pb = b_r;
    always @(posedge mclk) begin
        if (step && dual) begin
            a_r <= !a_r;
            b_r <= !b_r;
        end else if (step && two_pulse) begin
            a_r <= dir ? a_r : !a_r;
            b_r <= dir ? !b_r : b_r;
        end else if (step) begin
            // Gray order, A leads when dir is 0
            a_r <= (a_r ^ b_r ^ dir) ? a_r : !a_r;
            b_r <= (a_r ^ b_r ^ dir) ? !b_r : b_r;
        end
    end
endmodule

// *** verif/apcq_tb.sv ***
// Purpose: Self-checking bench for the axis position counters
// Assumes: Phase paths settle within eight cycles
// Notes: Deviation is the first source minus the second
`timescale 1ns/1ps
module apcq_tb;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic epa, epb, hpa, hpb, avs_waitrequest, irq;
    logic cmd_pulse = 1'h0, cmd_dir = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic e_step = 1'h0, e_dir = 1'h0, e_dual = 1'h0, h_step = 1'h0, h_dir = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic [1:0] fmt = 2'h0;
    logic rev = 1'h0, off = 1'h0;
    int seed, errors = 0, checked = 0, e_enc = 0, e_cmd = 0, e_hw = 0;
    always #50 mclk = ~mclk;
    apcq_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .encoder_phase_a(epa),
        .encoder_phase_b(epb), .handwheel_phase_a(hpa), .handwheel_phase_b(hpb),
        .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
    apcq_phase_model enc_u (.mclk(mclk), .step(e_step), .dir(e_dir), .dual(e_dual),
        .two_pulse(fmt == 2'h3), .pa(epa), .pb(epb));
    apcq_phase_model hw_u (.mclk(mclk), .step(h_step), .dir(h_dir), .dual(1'h0),
        .two_pulse(1'h0), .pa(hpa), .pb(hpb));
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'h0) @(posedge mclk);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge mclk);
    endtask
    function automatic int delta(input logic [1:0] f, input logic r, input logic o,
        input logic oa, input logic ob, input logic na, input logic nb);
        int d;
        d = 0;
        if (o || (oa != na && ob != nb)) return 0;
        if (f == 2'h3) d = (na && !oa) ? 1 : ((nb && !ob) ? -1 : 0);
        else if (oa != na) begin
            if (f != 2'h0 || !ob) d = (na != ob) ? 1 : -1;
        end else if (ob != nb && f == 2'h2) d = (nb == oa) ? 1 : -1;
        return r ? -d : d;
    endfunction
    task move(input int src);
        logic oa, ob, d;
        d = $random(seed);
        oa = src == 1 ? hpa : epa;
        ob = src == 1 ? hpb : epb;
        cmd_dir <= d;
        cmd_pulse <= src == 2;
        e_dir <= d;
        e_step <= src == 0;
        h_dir <= d;
        h_step <= src == 1;
        @(posedge mclk);
        cmd_pulse <= 1'h0;
        e_step <= 1'h0;
        h_step <= 1'h0;
        // Gap of 2 or 4: a gap of 3 lands a command on a phase step
        repeat (2 + 2 * ({$random(seed)} % 2)) @(posedge mclk);
        if (src == 2) e_cmd += d ? -1 : 1;
        else if (src == 1) e_hw += delta(2'h2, 1'h0, 1'h0, oa, ob, hpa, hpb);
        else e_enc += delta(fmt, rev, off, oa, ob, epa, epb);
    endtask
    task verify(input logic [1:0] c2, input logic [1:0] dv, input logic [1:0] c4);
        int t[3];
        logic [15:0] w;
        repeat (8) @(posedge mclk);
        t = '{e_enc, e_cmd, e_hw};
        w = dv == 2'h0 ? e_cmd - e_enc : (dv == 2'h1 ? e_cmd - e_hw : e_enc - e_hw);
        bus(1'h0, 5'h0C, 32'h0);
        check("ctr1", q, 32'(e_cmd));
        bus(1'h0, 5'h10, 32'h0);
        check("ctr2", q, 32'(t[c2]));
        bus(1'h0, 5'h14, 32'h0);
        check("ctr3", q, {16'h0, w});
        bus(1'h0, 5'h18, 32'h0);
        check("ctr4", q, 32'(c4 == 2'h0 ? e_cmd : (c4 == 2'h1 ? e_enc : e_hw)));
    endtask
    task run(input logic [1:0] c2, dv, c4, f, input logic rv, of, input int n);
        fmt = f;
        rev = rv;
        off = of;
        bus(1'h1, 5'h00, {16'h0, 3'h0, 2'h2, 1'($random(seed)), of, rv, f, c4, dv, c2});
        for (int i = 3; i < 7; i++) bus(1'h1, 5'(4 * i), 32'h0);
        e_enc = 0;
        e_cmd = 0;
        e_hw = 0;
        repeat (n) move({$random(seed)} % 3);
        verify(c2, dv, c4);
    endtask
    task fault;
        e_dual <= 1'h1;
        e_step <= 1'h1;
        @(posedge mclk);
        e_dual <= 1'h0;
        e_step <= 1'h0;
        repeat (8) @(posedge mclk);
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        results;
    end
    initial begin
        seed = 4357;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            bus(1'h0, 5'(4 * i), 32'h0);
            check("reset", q, 32'h0);
        end
        repeat (12) move({$random(seed)} % 3);
        verify(2'h0, 2'h0, 2'h0);
        bus(1'h1, 5'h0C, 32'h89ABCDEF);
        bus(1'h0, 5'h0C, 32'h0);
        check("ctr1_width", q, 32'h89ABCDEF);
        bus(1'h1, 5'h14, 32'hFFFF1234);
        bus(1'h0, 5'h14, 32'h0);
        check("ctr3_width", q, 32'h00001234);
        for (int f = 0; f < 8; f++) run(0, 0, 0, 2'(f), 1'(f >> 2), 0, 16);
        for (int s = 0; s < 3; s++) run(2'(s), 2'(s), 2'(s), 2'h2, 0, 0, 12);
        run(0, 0, 1, 2'h2, 0, 1, 12);
        bus(1'h1, 5'h00, 32'h30);
        bus(1'h1, 5'h18, 32'h0);
        repeat (40) @(posedge mclk);
        bus(1'h0, 5'h18, 32'h0);
        check("ctr4_half", (q >= 19 && q <= 24) ? 32'h0 : q, 32'h0);
        run(0, 0, 0, 2'h2, 0, 0, 2);
        bus(1'h1, 5'h08, 32'h1);
        fault;
        check("irq_set", {31'h0, irq}, 32'h1);
        bus(1'h0, 5'h04, 32'h0);
        check("status", q, 32'h1);
        @(posedge mclk);
        check("irq_clear", {31'h0, irq}, 32'h0);
        repeat (8) move(0);
        verify(2'h0, 2'h0, 2'h0);
        run(0, 0, 0, 2'h2, 0, 1, 0);
        fault;
        bus(1'h0, 5'h04, 32'h0);
        check("status_off", q, 32'h0);
        results;
    end
endmodule
